// file: dsp_sync_gen.sv
// display sync pulse generator with AXI4-Lite register slave
// How it works
// [RQ1] hsync rises when pixel count hits begin
// [RQ2] hsync falls when pixel count hits end
// [RQ3] field 1 vsync rises at begin line/pixel
// [RQ4] field 1 vsync falls at end line/pixel
// [RQ5] field 2 vsync rises at begin line/pixel
// [RQ6] field 2 vsync falls at end line/pixel
// [RQ7] hsync register: end 27-16, begin 11-0
// [RQ8] field 1 begin register: line, pixel
// [RQ9] field 1 end register: line, pixel
// [RQ10] field 2 begin register: line, pixel
// [RQ11] reserved bits read zero, writes ignored
// [RQ12] all position fields reset to zero
// [RQ13] field selects positions; vsync holds between
`timescale 1ns/100ps

module dsp_sync_gen
	import dsp_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	input  wire logic                 core_clk_i,
	input  wire logic                 nrst_i,
	input  wire logic [ADDR_W-1:0]    s_axi_awaddr_i,
	input  wire logic [2:0]           s_axi_awprot_i,
	input  wire logic                 s_axi_awvalid_i,
	output logic                      s_axi_awready_o,
	input  wire logic [31:0]          s_axi_wdata_i,
	input  wire logic [3:0]           s_axi_wstrb_i,
	input  wire logic                 s_axi_wvalid_i,
	output logic                      s_axi_wready_o,
	output logic [1:0]                s_axi_bresp_o,
	output logic                      s_axi_bvalid_o,
	input  wire logic                 s_axi_bready_i,
	input  wire logic [ADDR_W-1:0]    s_axi_araddr_i,
	input  wire logic [2:0]           s_axi_arprot_i,
	input  wire logic                 s_axi_arvalid_i,
	output logic                      s_axi_arready_o,
	output logic [31:0]               s_axi_rdata_o,
	output logic [1:0]                s_axi_rresp_o,
	output logic                      s_axi_rvalid_o,
	input  wire logic                 s_axi_rready_i,
	input  wire logic [DSP_POS_W-1:0] frame_pixel_counter_i,
	input  wire logic [DSP_POS_W-1:0] frame_line_counter_i,
	input  wire logic                 field2_active_i,
	output logic                      hsync_o,
	output logic                      vsync_o
);

	dsp_pair_type          pos_reg [DSP_NUM_POS];
	dsp_sync_type          sync_reg;
	dsp_sync_type          sync_next;

	logic                  aw_full_reg;
	logic [ADDR_W-1:0]     aw_addr_reg;
	logic                  w_full_reg;
	logic [31:0]           w_data_reg;
	logic [3:0]            w_strb_reg;
	logic                  bvalid_reg;
	logic [1:0]            bresp_reg;
	logic                  rvalid_reg;
	logic [1:0]            rresp_reg;
	logic [31:0]           rdata_reg;

	logic                  do_write;
	logic [ADDR_W-3:0]     wr_index;
	logic [ADDR_W-3:0]     rd_index;
	logic                  wr_is_pos;
	logic                  wr_mapped;
	logic [31:0]           rd_word;
	logic                  rd_mapped;

	dsp_pair_type          v_begin;
	dsp_pair_type          v_end;
	logic                  h_begin_hit;
	logic                  h_end_hit;
	logic                  v_begin_hit;
	logic                  v_end_hit;

	// spread a pair into its bus word with the reserved nibbles forced low
	function automatic logic [31:0] pair_to_word(input dsp_pair_type p);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[DSP_UPPER_LSB +: DSP_POS_W] = p.upper;
		w[DSP_LOWER_LSB +: DSP_POS_W] = p.lower;
		return w;
	endfunction : pair_to_word

	// byte-lane merge; bits outside the two fields are simply dropped
	function automatic dsp_pair_type merge_write(input dsp_pair_type old_p,
		input logic [31:0] data, input logic [3:0] strb);
		logic [31:0]  w;
		dsp_pair_type p;
		w = pair_to_word(old_p);
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				w[b*8 +: 8] = data[b*8 +: 8];
			end
		end
		p.upper = w[DSP_UPPER_LSB +: DSP_POS_W];
		p.lower = w[DSP_LOWER_LSB +: DSP_POS_W];
		return p;
	endfunction : merge_write

	// write channel: address and data are caught independently, in any order
	assign s_axi_awready_o = !aw_full_reg;
	assign s_axi_wready_o  = !w_full_reg;
	assign do_write        = aw_full_reg && w_full_reg && !bvalid_reg;
	assign wr_index        = aw_addr_reg[ADDR_W-1:2];
	assign wr_is_pos       = wr_index < (ADDR_W-2)'(DSP_NUM_POS);
	assign wr_mapped       = wr_is_pos || (wr_index == DSP_OFS_STATUS[ADDR_W-1:2]);

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			aw_full_reg <= 1'b0;
			aw_addr_reg <= '0;
		end else if (s_axi_awvalid_i && !aw_full_reg) begin
			aw_full_reg <= 1'b1;
			aw_addr_reg <= s_axi_awaddr_i;
		end else if (do_write) begin
			aw_full_reg <= 1'b0;
		end
	end

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			w_full_reg <= 1'b0;
			w_data_reg <= 32'h0000_0000;
			w_strb_reg <= 4'h0;
		end else if (s_axi_wvalid_i && !w_full_reg) begin
			w_full_reg <= 1'b1;
			w_data_reg <= s_axi_wdata_i;
			w_strb_reg <= s_axi_wstrb_i;
		end else if (do_write) begin
			w_full_reg <= 1'b0;
		end
	end

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			bvalid_reg <= 1'b0;
			bresp_reg  <= DSP_RESP_OKAY;
		end else if (do_write) begin
			bvalid_reg <= 1'b1;
			bresp_reg  <= wr_mapped ? DSP_RESP_OKAY : DSP_RESP_SLVERR;
		end else if (s_axi_bready_i) begin
			bvalid_reg <= 1'b0;
		end
	end

	assign s_axi_bvalid_o = bvalid_reg;
	assign s_axi_bresp_o  = bresp_reg;

	// position registers, one per generate entry
	for (genvar g = 0; g < DSP_NUM_POS; g++) begin : g_pos
		always_ff @(posedge core_clk_i or negedge nrst_i) begin
			if (!nrst_i) begin
				pos_reg[g].upper <= DSP_POS_RESET; // RQ12
				pos_reg[g].lower <= DSP_POS_RESET; // RQ12
			end else if (do_write && wr_index == (ADDR_W-2)'(g)) begin
				pos_reg[g] <= merge_write(pos_reg[g], w_data_reg, w_strb_reg); // RQ7 RQ8 RQ9 RQ10 RQ11
			end
		end
	end

	// read channel: one read in flight, data registered
	assign rd_index = s_axi_araddr_i[ADDR_W-1:2];

	always_comb begin
		rd_word   = 32'h0000_0000;
		rd_mapped = 1'b1;
		if (rd_index < (ADDR_W-2)'(DSP_NUM_POS)) begin
			rd_word = pair_to_word(pos_reg[rd_index[2:0]]); // RQ11
		end else if (rd_index == DSP_OFS_STATUS[ADDR_W-1:2]) begin
			rd_word[DSP_STAT_HSYNC_BIT] = sync_reg.hsync;
			rd_word[DSP_STAT_VSYNC_BIT] = sync_reg.vsync;
			rd_word[DSP_STAT_FIELD_BIT] = field2_active_i;
		end else begin
			rd_mapped = 1'b0;
		end
	end

	assign s_axi_arready_o = !rvalid_reg;

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rvalid_reg <= 1'b0;
			rresp_reg  <= DSP_RESP_OKAY;
			rdata_reg  <= 32'h0000_0000;
		end else if (s_axi_arvalid_i && !rvalid_reg) begin
			rvalid_reg <= 1'b1;
			rresp_reg  <= rd_mapped ? DSP_RESP_OKAY : DSP_RESP_SLVERR;
			rdata_reg  <= rd_word;
		end else if (s_axi_rready_i) begin
			rvalid_reg <= 1'b0;
		end
	end

	assign s_axi_rvalid_o = rvalid_reg;
	assign s_axi_rresp_o  = rresp_reg;
	assign s_axi_rdata_o  = rdata_reg;

	// sync compare; field input picks which vertical pair is live
	assign v_begin = field2_active_i ? pos_reg[DSP_IDX_F2_VBEGIN]
	                                 : pos_reg[DSP_IDX_F1_VBEGIN]; // RQ13
	assign v_end   = field2_active_i ? pos_reg[DSP_IDX_F2_VEND]
	                                 : pos_reg[DSP_IDX_F1_VEND]; // RQ13

	assign h_begin_hit = frame_pixel_counter_i == pos_reg[DSP_IDX_HSYNC].lower; // RQ1
	assign h_end_hit   = frame_pixel_counter_i == pos_reg[DSP_IDX_HSYNC].upper; // RQ2
	assign v_begin_hit = (frame_line_counter_i == v_begin.upper)
	                  && (frame_pixel_counter_i == v_begin.lower); // RQ3 RQ5
	assign v_end_hit   = (frame_line_counter_i == v_end.upper)
	                  && (frame_pixel_counter_i == v_end.lower); // RQ4 RQ6

	// end match wins over begin so equal settings give no pulse at all
	always_comb begin
		sync_next = sync_reg;
		if (h_end_hit) begin
			sync_next.hsync = 1'b0; // RQ2
		end else if (h_begin_hit) begin
			sync_next.hsync = 1'b1; // RQ1
		end
		if (v_end_hit) begin
			sync_next.vsync = 1'b0; // RQ4 RQ6
		end else if (v_begin_hit) begin
			sync_next.vsync = 1'b1; // RQ3 RQ5
		end
	end

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sync_reg <= '0;
		end else begin
			sync_reg <= sync_next; // RQ13
		end
	end

	assign hsync_o = sync_reg.hsync;
	assign vsync_o = sync_reg.vsync;

endmodule : dsp_sync_gen

// file: dsp_pkg.sv
// display sync pulse generator: register map, field layout and carrier types
package dsp_pkg;

	localparam int          DSP_POS_W          = 12;
	localparam int          DSP_LOWER_LSB      = 0;
	localparam int          DSP_UPPER_LSB      = 16;
	localparam int          DSP_NUM_POS        = 5;

	localparam logic [7:0]  DSP_OFS_HSYNC      = 8'h00;
	localparam logic [7:0]  DSP_OFS_F1_VBEGIN  = 8'h04;
	localparam logic [7:0]  DSP_OFS_F1_VEND    = 8'h08;
	localparam logic [7:0]  DSP_OFS_F2_VBEGIN  = 8'h0c;
	localparam logic [7:0]  DSP_OFS_F2_VEND    = 8'h10;
	localparam logic [7:0]  DSP_OFS_STATUS     = 8'h14;

	localparam int          DSP_IDX_HSYNC      = 0;
	localparam int          DSP_IDX_F1_VBEGIN  = 1;
	localparam int          DSP_IDX_F1_VEND    = 2;
	localparam int          DSP_IDX_F2_VBEGIN  = 3;
	localparam int          DSP_IDX_F2_VEND    = 4;

	localparam logic [11:0] DSP_POS_RESET      = 12'h000;

	localparam int          DSP_STAT_HSYNC_BIT = 0;
	localparam int          DSP_STAT_VSYNC_BIT = 1;
	localparam int          DSP_STAT_FIELD_BIT = 2;

	localparam logic [1:0]  DSP_RESP_OKAY      = 2'b00;
	localparam logic [1:0]  DSP_RESP_SLVERR    = 2'b10;

	// upper: end pixel or line, lower: begin pixel or pixel of the vertical point
	typedef struct packed {
		logic [DSP_POS_W-1:0] upper;
		logic [DSP_POS_W-1:0] lower;
	} dsp_pair_type;

	typedef struct packed {
		logic hsync;
		logic vsync;
	} dsp_sync_type;

endpackage : dsp_pkg

// file: dsp_sync_gen_asserts.sv
// port checker for the display sync generator
`timescale 1ns/100ps
module dsp_sync_chk
	import dsp_pkg::*;
#(parameter int ADDR_W = 8) (
	input wire logic                 core_clk_i,
	input wire logic                 nrst_i,
	input wire logic [ADDR_W-1:0]    s_axi_awaddr_i,
	input wire logic                 s_axi_awvalid_i,
	input wire logic                 s_axi_awready_o,
	input wire logic [31:0]          s_axi_wdata_i,
	input wire logic                 s_axi_wvalid_i,
	input wire logic                 s_axi_wready_o,
	input wire logic                 s_axi_bvalid_o,
	input wire logic                 s_axi_arvalid_i,
	input wire logic                 s_axi_arready_o,
	input wire logic [31:0]          s_axi_rdata_o,
	input wire logic                 s_axi_rvalid_o,
	input wire logic [DSP_POS_W-1:0] frame_pixel_counter_i,
	input wire logic                 hsync_o
);
	logic         wr_go, go_reg, hb_hit, he_hit;
	logic [31:0]  pend_reg;
	dsp_pair_type hs_reg;
	assign wr_go = s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
	assign hb_hit = frame_pixel_counter_i == hs_reg.lower;
	assign he_hit = frame_pixel_counter_i == hs_reg.upper;
	// shadow stores one edge after the take, as the slave does; full strobes only
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			go_reg   <= 1'b0;
			hs_reg   <= '0;
			pend_reg <= 32'h0000_0000;
		end else begin
			go_reg <= wr_go && s_axi_awaddr_i[ADDR_W-1:2] == '0;
			if (wr_go) pend_reg <= s_axi_wdata_i;
			if (go_reg) hs_reg <= {pend_reg[27:16], pend_reg[11:0]};
		end
	end
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!nrst_i);
	a_hsync_rise: assert property (hb_hit && !he_hit |=> hsync_o)
		else $error("hsync missed its begin pixel");
	a_hsync_fall: assert property (he_hit |=> !hsync_o)
		else $error("hsync missed its end pixel");
	a_hsync_hold: assert property (!hb_hit && !he_hit |=> $stable(hsync_o))
		else $error("hsync moved without a match");
	a_rise_cause: assert property ($rose(hsync_o) |-> $past(hb_hit))
		else $error("hsync rose off its begin pixel");
	a_fall_cause: assert property ($fell(hsync_o) |-> $past(he_hit))
		else $error("hsync fell off its end pixel");
	a_write_answer: assert property (wr_go |=> !s_axi_awready_o ##1 s_axi_bvalid_o)
		else $error("write answer late");
	a_read_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
		else $error("read answer late");
	a_rsvd_zero: assert property (s_axi_rvalid_o |-> !s_axi_rdata_o[31:28] && !s_axi_rdata_o[15:12])
		else $error("reserved bits read nonzero");
	cover property (hb_hit ##1 hsync_o);
	cover property ($fell(hsync_o));
	cover property (wr_go);
endmodule : dsp_sync_chk

bind dsp_sync_gen dsp_sync_chk #(.ADDR_W(ADDR_W)) u_chk (.*);

// file: dsp_display_model.sv
// far-side display model: free-running raster position source
`timescale 1ns/100ps
module dsp_display_model
	import dsp_pkg::*;
#(
	parameter int PIX_N  = 16,
	parameter int LINE_N = 4
) (
	input  wire logic            core_clk_i,
	input  wire logic            nrst_i,
	output logic [DSP_POS_W-1:0] pix_o,
	output logic [DSP_POS_W-1:0] line_o
);
	// tiny raster keeps a whole frame to 64 cycles
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pix_o <= '0;
			line_o <= '0;
		end else if (pix_o == DSP_POS_W'(PIX_N - 1)) begin
			pix_o <= '0;
			line_o <= (line_o == DSP_POS_W'(LINE_N - 1)) ? '0 : line_o + 1'b1;
		end else begin
			pix_o <= pix_o + 1'b1;
		end
	end
endmodule : dsp_display_model

// file: dsp_sync_gen_tb.sv
// self-checking bench for the display sync generator
`timescale 1ns/100ps
module dsp_sync_gen_tb
	import dsp_pkg::*;
;
	typedef struct packed {logic [7:0] a; logic [31:0] d, e; logic [1:0] r;} dsp_row_type;
	logic core_clk_i, nrst_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i;
	logic s_axi_arvalid_i, s_axi_rready_i, field2_active_i, hsync_o, vsync_o;
	logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
	logic [7:0]  s_axi_awaddr_i, s_axi_araddr_i;
	logic [31:0] s_axi_wdata_i, s_axi_rdata_o, got, hs_n, vs_n;
	logic [2:0]  s_axi_awprot_i, s_axi_arprot_i;
	logic [3:0]  s_axi_wstrb_i;
	logic [1:0]  s_axi_bresp_o, s_axi_rresp_o, resp;
	logic [11:0] frame_pixel_counter_i, frame_line_counter_i;
	int          err_total, n_checks;
	dsp_row_type rows [6];
	dsp_sync_gen uut (.*);
	dsp_display_model u_disp (.core_clk_i, .nrst_i, .pix_o(frame_pixel_counter_i),
		.line_o(frame_line_counter_i));
	initial begin
		core_clk_i = 1'b0;
		forever #2 core_clk_i = ~core_clk_i;
	end
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("Error %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task close_out;
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : close_out
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk_i);
		s_axi_awaddr_i <= a;
		s_axi_wdata_i <= d;
		{s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} <= 3'h7;
		do begin
			@(posedge core_clk_i);
			if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
			if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
		end while (s_axi_awvalid_i || s_axi_wvalid_i);
		do @(posedge core_clk_i); while (!s_axi_bvalid_o);
		resp = s_axi_bresp_o;
		s_axi_bready_i <= 1'b0;
	endtask : wr
	task rd(input logic [7:0] a);
		@(posedge core_clk_i);
		s_axi_araddr_i <= a;
		{s_axi_arvalid_i, s_axi_rready_i} <= 2'h3;
		do @(posedge core_clk_i); while (!s_axi_arready_o);
		s_axi_arvalid_i <= 1'b0;
		do @(posedge core_clk_i); while (!s_axi_rvalid_o);
		got = s_axi_rdata_o;
		resp = s_axi_rresp_o;
		s_axi_rready_i <= 1'b0;
	endtask : rd
	// settle one frame, then count high cycles over the next
	task frame;
		{hs_n, vs_n} = '0;
		repeat (64) @(posedge core_clk_i);
		repeat (64) begin
			@(negedge core_clk_i);
			hs_n = hs_n + hsync_o;
			vs_n = vs_n + vsync_o;
		end
	endtask : frame
	initial begin
		#40000;
		err_total++;
		close_out();
	end
	initial begin
		{s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, nrst_i} = '0;
		{s_axi_arvalid_i, s_axi_rready_i, field2_active_i} = '0;
		{s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i, s_axi_awprot_i, s_axi_arprot_i} = '0;
		s_axi_wstrb_i = 4'hf;
		rows = '{'{8'h00, 32'hffffffff, 32'h0fff0fff, DSP_RESP_OKAY},
			'{8'h04, 32'ha5a5a5a5, 32'h05a505a5, DSP_RESP_OKAY},
			'{8'h08, 32'h5a5a5a5a, 32'h0a5a0a5a, DSP_RESP_OKAY},
			'{8'h0c, 32'h12345678, 32'h02340678, DSP_RESP_OKAY},
			'{8'h10, 32'hffffffff, 32'h0fff0fff, DSP_RESP_OKAY},
			'{8'h18, 32'hffffffff, 32'h00000000, DSP_RESP_SLVERR}};
		repeat (12) @(posedge core_clk_i);
		nrst_i <= 1'b1;
		for (int i = 0; i < 5; i++) begin
			rd(8'(i * 4));
			chk(got, 32'h0);
		end
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d);
			chk(32'(resp), 32'(rows[i].r));
			rd(rows[i].a);
			chk(got, rows[i].e);
			chk(32'(resp), 32'(rows[i].r));
		end
		wr(8'h00, 32'h00070003);
		wr(8'h04, 32'h00010002);
		wr(8'h08, 32'h00020005);
		frame();
		chk(hs_n, 32'd16);
		chk(vs_n, 32'd19);
		wr(8'h0c, 32'h00000001);
		wr(8'h10, 32'h00030000);
		field2_active_i <= 1'b1;
		wr(8'h00, 32'h00050005);
		frame();
		chk(vs_n, 32'd47);
		chk(hs_n, 32'd0);
		@(posedge core_clk_i);
		nrst_i <= 1'b0;
		repeat (2) @(posedge core_clk_i);
		chk({vsync_o, hsync_o}, 32'h0);
		nrst_i <= 1'b1;
		rd(8'h0c);
		chk(got, 32'h0);
		// status after reset: both syncs low, field 2 still selected
		rd(8'h14);
		chk(got, 32'h4);
		wr(8'h14, 32'hffffffff);
		chk(32'(resp), 32'(DSP_RESP_OKAY));
		close_out();
	end
endmodule : dsp_sync_gen_tb
